// File: src/fpa_fp32_datapath.v
// Behaviour
// - Exponent field is true exponent plus 127.
// - Hidden bit is 1 for normalized operands, 0 for zero or denormal.
// - Fraction top bit weighs 2^-1, bottom 2^-23, hidden bit 2^0.
// - Affine option keeps the sign of infinity.
// - Fast multiply flushes denormal inputs and underflows to zero.
// - Flowthrough makes the last two internal pipeline registers transparent.
// - Pipeline holds five operations: load, three array stages, output.
// - Every arithmetic result except a wrapped or a fast-mode flushed multiplier underflow is rounded to a 24-bit significand.
// - Upper half loads first; stage one starts on it during lower load.
// - ALU stage one compares exponents, flags larger, stores difference.
// - Align smaller significand by the difference, then add.
// - Stage two counts normalize shift, complements negative sums.
// - Stage three rounds, normalizes, adjusts exponent, flags exceptions.
// - Inexact is raised when any discarded bit is one, except when a multiplier denormal operand is flagged.
// - Multiplier widens exponents, skips alignment, adds exponents, multiplies.
// - Multiplier rounds, checks range; underflow by mode bit, overflow by rounding.
// - Four rounding modes, round-to-nearest among them.
// - Normalized means hidden bit one and exponent -126 to 127.
// - Upper halves taken on the load edge, lower halves on the next.
// - Three-bit status encodes exceptions and multiplier denormal operand.
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fpa_consts.vh"

module fpa_fp32_datapath #(
  parameter HALF_W = 16
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [3:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire [HALF_W-1:0] opa_i,
  input  wire [HALF_W-1:0] opb_i,
  input  wire [3:0]        func_i,
  input  wire [1:0]        load_control_inputs_i,
  input  wire [1:0]        unload_i,
  output reg  [HALF_W-1:0] result_o,
  output reg               result_oe_n_o,
  output reg  [2:0]        exception_status_outputs_o,
  output reg               done_o
);

  function [5:0] fpa_lzc;
    input [47:0] v;
    integer i;
    reg     f;
    begin
      fpa_lzc = 6'd48;
      f = 1'b0;
      for (i = 47; i >= 0; i = i - 1)
        if (!f && v[i])
        begin
          fpa_lzc = 6'd47 - i[5:0];
          f = 1'b1;
        end
    end
  endfunction

  reg  [6:0]  ctrl_q;
  wire [1:0]  rnd_mode = ctrl_q[`FPA_C_RND];
  wire        mul_mode = ctrl_q[`FPA_C_MUL];
  wire        fast     = ctrl_q[`FPA_C_FAST];
  wire        affine   = ctrl_q[`FPA_C_AFFINE];
  wire        flow     = ctrl_q[`FPA_C_FLOW];
  wire        underflow_result_select_bit = ctrl_q[`FPA_C_UFSEL];

  // Load stage: upper halves and function code
  reg  [15:0] hi_a_q;
  reg  [15:0] hi_b_q;
  reg  [3:0]  fn_q;
  reg         hi_v_q;
  reg  [15:0] lo_a_q;
  reg  [15:0] lo_b_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_a_q <= 16'h0000;
      hi_b_q <= 16'h0000;
      fn_q   <= 4'h0;
      hi_v_q <= 1'b0;
      lo_a_q <= 16'h0000;
      lo_b_q <= 16'h0000;
    end
    else
    begin
      hi_v_q <= (load_control_inputs_i == `FPA_LD_BOTH);
      if (load_control_inputs_i == `FPA_LD_BOTH)
      begin
        hi_a_q <= opa_i[15:0];
        hi_b_q <= opb_i[15:0];
        fn_q   <= func_i;
      end
      if (hi_v_q)
      begin
        lo_a_q <= opa_i[15:0];
        lo_b_q <= opb_i[15:0];
      end
    end
  end

  // Stage 1/2: exponent work on the upper halves only
  wire [7:0]         ea  = hi_a_q[14:7];
  wire [7:0]         eb  = hi_b_q[14:7];
  wire               wa  = mul_mode & fn_q[0];
  wire               wb  = mul_mode & fn_q[1];
  wire               ha  = (|ea) | wa;
  wire               hb  = (|eb) | wb;
  wire signed [11:0] xa  = wa ? {ea[7] ? `FPA_EXP_WRAP : 4'h0, ea} : {4'h0, (|ea) ? ea : 8'h01};
  wire signed [11:0] xb  = wb ? {eb[7] ? `FPA_EXP_WRAP : 4'h0, eb} : {4'h0, (|eb) ? eb : 8'h01};
  wire               agt = (xa >= xb);
  wire signed [11:0] dif = agt ? xa - xb : xb - xa;
  wire signed [11:0] e0  = mul_mode ? xa + xb - `FPA_EXP_BIAS : (agt ? xa : xb);

  reg  signed [11:0] s0_e_q;
  reg  [11:0]        s0_dif_q;
  reg  [7:0]         s0_fa_q;
  reg  [7:0]         s0_fb_q;
  reg  [3:0]         s0_fn_q;
  reg                s0_gt_q;
  reg                s0_sa_q;
  reg                s0_sb_q;
  reg                s0_ma_q;
  reg                s0_mb_q;
  reg                s0_wa_q;
  reg                s0_wb_q;
  reg                s0_v_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s0_e_q   <= 12'sd0;
      s0_dif_q <= 12'h000;
      s0_fa_q  <= 8'h00;
      s0_fb_q  <= 8'h00;
      s0_fn_q  <= 4'h0;
      s0_gt_q  <= 1'b0;
      s0_sa_q  <= 1'b0;
      s0_sb_q  <= 1'b0;
      s0_ma_q  <= 1'b0;
      s0_mb_q  <= 1'b0;
      s0_wa_q  <= 1'b0;
      s0_wb_q  <= 1'b0;
      s0_v_q   <= 1'b0;
    end
    else
    begin
      s0_v_q   <= hi_v_q;
      s0_e_q   <= e0;
      s0_dif_q <= dif;
      s0_gt_q  <= agt;
      s0_fa_q  <= {ha, hi_a_q[6:0]};
      s0_fb_q  <= {hb, hi_b_q[6:0]};
      s0_fn_q  <= fn_q;
      s0_sa_q  <= hi_a_q[15];
      s0_sb_q  <= hi_b_q[15];
      s0_ma_q  <= (ea == `FPA_EXP_ALLONE) & ~wa;
      s0_mb_q  <= (eb == `FPA_EXP_ALLONE) & ~wb;
      s0_wa_q  <= wa;
      s0_wb_q  <= wb;
    end
  end

  // Stage 1: align and add, or multiply
  wire [23:0] ma   = {s0_fa_q, lo_a_q};
  wire [23:0] mb   = {s0_fb_q, lo_b_q};
  wire        fra  = |{s0_fa_q[6:0], lo_a_q};
  wire        frb  = |{s0_fb_q[6:0], lo_b_q};
  wire        nan  = (s0_ma_q & fra) | (s0_mb_q & frb);
  wire        infa = s0_ma_q & ~fra;
  wire        infb = s0_mb_q & ~frb;
  wire        dna  = ~s0_fa_q[7] & fra & ~s0_wa_q;
  wire        dnb  = ~s0_fb_q[7] & frb & ~s0_wb_q;
  wire        zra  = ~s0_fa_q[7] & (~fra | (fast & mul_mode));
  wire        zrb  = ~s0_fb_q[7] & (~frb | (fast & mul_mode));
  wire        bsg  = s0_sb_q ^ (~mul_mode & s0_fn_q[0]);
  wire        eff_sub = s0_sa_q ^ bsg;
  wire [23:0] big  = s0_gt_q ? ma : mb;
  wire [23:0] sml  = s0_gt_q ? mb : ma;
  wire [4:0]  sh   = (s0_dif_q > 12'd27) ? 5'd27 : s0_dif_q[4:0];
  wire [26:0] sx   = {sml, 3'b000};
  wire [26:0] shd  = sx >> sh;
  wire        lost = |(sx & ~({27{1'b1}} << sh));
  wire [26:0] aln  = {shd[26:1], shd[0] | lost};
  wire [28:0] sum  = eff_sub ? {2'b00, big, 3'b000} - {2'b00, aln}
                             : {2'b00, big, 3'b000} + {2'b00, aln};
  wire [47:0] prod = ma * mb;
  wire        minv = (infa & zrb) | (zra & infb);
  wire        ainv = infa & infb & eff_sub;

  wire [69:0] s1_d = {
    mul_mode ? prod : {sum[27:0], 20'h00000},
    ~mul_mode & sum[28],
    mul_mode ? s0_sa_q ^ s0_sb_q : (s0_gt_q ? s0_sa_q : bsg),
    s0_e_q,
    nan | (mul_mode ? minv : ainv),
    infa | infb,
    mul_mode ? s0_sa_q ^ s0_sb_q : (infa ? s0_sa_q : bsg),
    mul_mode & (zra | zrb),
    nan | (mul_mode ? minv : ainv),
    mul_mode & ~fast & (dna | dnb),
    mul_mode,
    s0_v_q
  };
  reg  [69:0] s1_q;
  wire [69:0] s1 = flow ? s1_d : s1_q;

  wire [47:0]        v1;
  wire               n1;
  wire               g1;
  wire signed [11:0] e1;
  wire [7:0]         f1;
  assign {v1, n1, g1, e1, f1} = s1;

  // Stage 2: complement and normalize count
  wire [47:0] mag = n1 ? 48'h0 - v1 : v1;
  wire [74:0] s2_d = {mag, fpa_lzc(mag), g1 ^ n1, e1, f1};
  reg  [74:0] s2_q;
  wire [74:0] s2 = flow ? s2_d : s2_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 70'h0;
      s2_q <= 75'h0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Stage 3: normalize, round, range check
  wire [47:0]        m2;
  wire [5:0]         lz;
  wire               sg;
  wire signed [11:0] e2;
  wire               snan;
  wire               sinf;
  wire               isg;
  wire               szr;
  wire               sinv;
  wire               sdn;
  wire               smul;
  wire               sv;
  assign {m2, lz, sg, e2, snan, sinf, isg, szr, sinv, sdn, smul, sv} = s2;

  wire [47:0]        nrm = (lz == 6'd0) ? {1'b0, m2[47:1]} : m2 << (lz - 6'd1);
  wire               st0 = (lz == 6'd0) & m2[0];
  wire signed [11:0] e3  = e2 + 12'sd1 - $signed({6'b000000, lz});
  wire               tiny = (e3 < 12'sd1);
  wire signed [11:0] dnc = 12'sd1 - e3;
  wire [4:0]         dsh = (dnc > 12'sd31) ? 5'd31 : dnc[4:0];
  wire [47:0]        dsv = nrm >> dsh;
  wire               dst = |(nrm & ~({48{1'b1}} << dsh));
  wire               den = tiny & ~(smul & (fast | underflow_result_select_bit));
  wire [47:0]        fin = den ? dsv : nrm;
  wire [23:0]        kp  = fin[46:23];
  wire               gd  = fin[22];
  wire               sk  = (|fin[21:0]) | st0 | (den & dst);
  wire               inx = gd | sk;

  reg                inc;
  always @*
  begin
    case (rnd_mode)
      `FPA_ROUND_TO_NEAREST: inc = gd & (sk | kp[0]);
      `FPA_RND_ZERO:         inc = 1'b0;
      `FPA_RND_POS:          inc = ~sg & inx;
      `FPA_RND_NEG:          inc = sg & inx;
      default:               inc = 1'b0;
    endcase
  end

  wire [24:0]        rnd  = {1'b0, kp} + {24'h000000, inc};
  wire [22:0]        frc  = rnd[24] ? rnd[23:1] : rnd[22:0];
  wire signed [11:0] efin = den ? {11'h000, rnd[23]} : e3 + {11'h000, rnd[24]};
  wire               ovf  = ~den & (efin >= `FPA_EXP_OVF);
  wire               tinf = (rnd_mode == `FPA_ROUND_TO_NEAREST) |
                            ((rnd_mode == `FPA_RND_POS) & ~sg) |
                            ((rnd_mode == `FPA_RND_NEG) & sg);

  reg  [31:0] res_d;
  reg  [2:0]  sta_d;
  always @*
  begin
    res_d = {sg, efin[7:0], frc};
    sta_d = inx ? `FPA_ST_INX : `FPA_ST_NONE;
    if (snan | sinv)
    begin
      res_d = `FPA_QNAN;
      sta_d = `FPA_ST_INV;
    end
    else if (sinf)
    begin
      res_d = {affine & isg, `FPA_INF_MAG};
      sta_d = `FPA_ST_NONE;
    end
    else if (szr | (lz == 6'd48))
    begin
      res_d = {szr & sg, 31'h00000000};
      sta_d = `FPA_ST_NONE;
    end
    else if (ovf)
    begin
      res_d = {sg, tinf ? `FPA_INF_MAG : `FPA_MAXNORM};
      sta_d = `FPA_ST_OVF | `FPA_ST_INX;
    end
    else if (tiny & smul & fast)
    begin
      res_d = {sg, 31'h00000000};
      sta_d = `FPA_ST_UNF | `FPA_ST_INX;
    end
    else if (tiny & smul & underflow_result_select_bit)
    begin
      res_d = {sg, e3[7:0], nrm[45:23]};
      sta_d = `FPA_ST_UNF | (inx ? `FPA_ST_INX : `FPA_ST_NONE);
    end
    else if (den & inx)
      sta_d = `FPA_ST_UNF | `FPA_ST_INX;
    if (sdn)
      sta_d = `FPA_ST_DNR;
  end

  // Output stage
  reg  [31:0] res_q;
  reg  [2:0]  sta_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_q  <= 32'h00000000;
      sta_q  <= `FPA_ST_NONE;
      done_o <= 1'b0;
      exception_status_outputs_o <= `FPA_ST_NONE;
      result_o      <= 16'h0000;
      result_oe_n_o <= 1'b1;
    end
    else
    begin
      done_o <= sv;
      if (sv)
      begin
        res_q <= res_d;
        sta_q <= sta_d;
        exception_status_outputs_o <= sta_d;
      end
      // Drives only while an unload code is active
      result_oe_n_o <= (unload_i == `FPA_UL_OFF);
      if (unload_i == `FPA_UL_UPPER)
        result_o <= res_q[31:16];
      else if (unload_i == `FPA_UL_LOWER)
        result_o <= res_q[15:0];
    end
  end

  // Wishbone slave, one wait state, write commits on the ack edge
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire busy   = hi_v_q | s0_v_q | f1[0] | sv;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= `FPA_CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o)
      begin
        case (wb_adr_i)
          `FPA_ADR_CTRL: wb_dat_o <= {25'h0000000, ctrl_q};
          `FPA_ADR_STAT: wb_dat_o <= {28'h0000000, busy, sta_q};
          default:       wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wb_req & wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FPA_ADR_CTRL))
        ctrl_q <= wb_dat_i[6:0];
    end
  end

endmodule // fpa_fp32_datapath
`default_nettype wire

// File: src/fpa_consts.vh
`ifndef FPA_CONSTS_VH
`define FPA_CONSTS_VH
// Number format
`define FPA_EXP_BIAS    12'sd127
`define FPA_EXP_ALLONE  8'hff
`define FPA_EXP_OVF     12'sd255
`define FPA_EXP_WRAP    4'hf
`define FPA_QNAN        32'h7fc00000
`define FPA_MAXNORM     31'h7f7fffff
`define FPA_INF_MAG     31'h7f800000
// Load and unload controls
`define FPA_LD_BOTH     2'b01
`define FPA_UL_UPPER    2'b01
`define FPA_UL_LOWER    2'b10
`define FPA_UL_HOLD     2'b11
`define FPA_UL_OFF      2'b00
// Rounding modes
`define FPA_ROUND_TO_NEAREST 2'd0
`define FPA_RND_ZERO    2'd1
`define FPA_RND_POS     2'd2
`define FPA_RND_NEG     2'd3
// Exception status codes
`define FPA_ST_NONE     3'd0
`define FPA_ST_INX      3'd1
`define FPA_ST_UNF      3'd2
`define FPA_ST_OVF      3'd4
`define FPA_ST_INV      3'd6
`define FPA_ST_DNR      3'd7
// Register map, byte addresses
`define FPA_ADR_CTRL    4'h0
`define FPA_ADR_STAT    4'h4
`define FPA_CTRL_RST    7'h00
// Control fields
`define FPA_C_RND       1:0
`define FPA_C_MUL       2
`define FPA_C_FAST      3
`define FPA_C_AFFINE    4
`define FPA_C_FLOW      5
`define FPA_C_UFSEL     6
`endif

// File: verification/fpa_host.sv
`timescale 1ns/1ps
`default_nettype none
module fpa_host (
  input  wire logic        clk_i,
  input  wire logic        done_i,
  input  wire logic [2:0]  status_i,
  input  wire logic [15:0] result_i,
  output var  logic [15:0] opa_o,
  output var  logic [15:0] opb_o,
  output var  logic [3:0]  func_o,
  output var  logic [1:0]  load_o,
  output var  logic [1:0]  unload_o
);
  initial
  begin
    opa_o = '0;
    opb_o = '0;
    func_o = '0;
    load_o = '0;
    unload_o = '0;
  end

  task automatic run(input logic [31:0] a, b, input logic [3:0] f,
                     output logic [31:0] r, output logic [2:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    load_o <= 2'b01;
    opa_o <= a[31:16];
    opb_o <= b[31:16];
    func_o <= f;
    @(posedge clk_i);
    load_o <= 2'b00;
    opa_o <= a[15:0];
    opb_o <= b[15:0];
    func_o <= ~f;
    @(posedge clk_i);
    // Released lines show garbage, not the last half
    opa_o <= ~a[15:0];
    opb_o <= ~b[15:0];
    while (done_i !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    s = (n < 20) ? status_i : 3'bx;
    unload_o <= 2'b01;
    @(posedge clk_i);
    unload_o <= 2'b10;
    @(posedge clk_i);
    r[31:16] = result_i;
    unload_o <= 2'b11;
    @(posedge clk_i);
    r[15:0] = result_i;
    unload_o <= 2'b00;
    // A hung operation must never compare equal
    if (n >= 20)
      r = 'x;
  endtask
endmodule // fpa_host
`default_nettype wire

// File: verification/fpa_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fpa_chk #(
  parameter HALF_W = 16
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic [1:0]        load_control_inputs_i,
  input wire logic [1:0]        unload_i,
  input wire logic [HALF_W-1:0] result_o,
  input wire logic              result_oe_n_o,
  input wire logic [2:0]        exception_status_outputs_o,
  input wire logic              done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_done_source: assert property (done_o |->
    $past(load_control_inputs_i == 2'b01, 5) || $past(load_control_inputs_i == 2'b01, 3))
    else $error("done without a load at pipeline or flowthrough depth");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done wider than one cycle");
  a_status_moves: assert property (!$stable(exception_status_outputs_o) |-> done_o)
    else $error("status changed without a result");
  a_out_off: assert property (unload_i == 2'b00 |=> result_oe_n_o)
    else $error("output driven while unload disabled");
  a_out_on: assert property (unload_i != 2'b00 |=> !result_oe_n_o)
    else $error("output not driven while unloading");
  a_out_hold: assert property (unload_i == 2'b11 |=> $stable(result_o))
    else $error("result changed during hold");
endmodule // fpa_chk

bind fpa_fp32_datapath fpa_chk #(.HALF_W(HALF_W)) u_fpa_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .load_control_inputs_i(load_control_inputs_i),
  .unload_i(unload_i), .result_o(result_o), .result_oe_n_o(result_oe_n_o),
  .exception_status_outputs_o(exception_status_outputs_o), .done_o(done_o));
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        wb_cyc = 0;
  logic        wb_stb = 0;
  logic        wb_we = 0;
  logic [3:0]  wb_adr = 0;
  logic [3:0]  wb_sel = 0;
  logic [3:0]  sel_pat = 4'hf;
  logic [31:0] wb_dat = 0;
  logic [31:0] q;
  logic [31:0] r;
  logic [2:0]  s;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire  [15:0] opa, opb, res;
  wire  [3:0]  func;
  wire  [1:0]  ld, unl;
  wire  [2:0]  st;
  wire         done;
  int          error_cnt = 0;
  int          samples_checked = 0;

  initial forever #2.5 clk_i = ~clk_i;

  fpa_fp32_datapath u_fpa_fp32_datapath (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .opa_i(opa), .opb_i(opb), .func_i(func),
    .load_control_inputs_i(ld), .unload_i(unl), .result_o(res), .result_oe_n_o(),
    .exception_status_outputs_o(st), .done_o(done));

  fpa_host u_fpa_host (
    .clk_i(clk_i), .done_i(done), .status_i(st), .result_i(res), .opa_o(opa),
    .opb_o(opb), .func_o(func), .load_o(ld), .unload_o(unl));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= w;
    wb_sel <= sel_pat;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask

  // Status bit 3 set means the status is not compared
  task op(input logic [31:0] a, b, input logic [3:0] f, input logic [31:0] er,
          input logic [3:0] es);
    u_fpa_host.run(a, b, f, r, s);
    chk(r, er);
    if (!es[3]) chk({29'h0, s}, {28'h0, es});
  endtask

  task results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    results;
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 4'h0, 0); chk(q, 0);
    wb(1, 4'h0, 32'h7f); wb(0, 4'h0, 0); chk(q, 32'h7f);
    wb(1, 4'h4, 32'hf); wb(0, 4'h4, 0); chk(q, 0);
    wb(1, 4'h8, 32'hff); wb(0, 4'h8, 0); chk(q, 0);
    wb(1, 4'h0, 0);
    // Control write without byte lane 0 is ignored
    sel_pat = 4'he;
    wb(1, 4'h0, 32'h7f);
    sel_pat = 4'hf;
    wb(0, 4'h0, 0);
    chk(q, 0);
    $display("test registers done");
    op(32'h41e80000, 32'h40d00000, 4'h0, 32'h420e0000, 4'h0);
    op(32'h40d00000, 32'h41e80000, 4'h1, 32'hc1b40000, 4'h0);
    op(32'h41e80000, 32'h41e80000, 4'h1, 32'h00000000, 4'h0);
    op(32'h00000001, 32'h00400000, 4'h0, 32'h00400001, 4'h0);
    op(32'h00400000, 32'h00400000, 4'h0, 32'h00800000, 4'h0);
    for (int m = 0; m < 4; m++)
    begin
      wb(1, 4'h0, m);
      op(32'h3f800000, 32'h33800000, 4'h0, (m == 2) ? 32'h3f800001 : 32'h3f800000, 4'h1);
    end
    wb(1, 4'h0, 0);
    op({{8{1'b1}}, 24'hffffff}, 32'h3f800000, 4'h0, 32'h7fc00000, 4'h6);
    op(32'h7f7fffff, 32'h7f7fffff, 4'h0, 32'h7f800000, 4'h5);
    wb(0, 4'h4, 0);
    chk(q, 32'h5);
    op(32'h7f800000, 32'h7f800000, 4'h1, 32'h7fc00000, 4'h6);
    op(32'hff800000, 32'h3f800000, 4'h0, 32'h7f800000, 4'h8);
    wb(1, 4'h0, 32'h10);
    op(32'hff800000, 32'h3f800000, 4'h0, 32'hff800000, 4'h8);
    $display("test alu done");
    wb(1, 4'h0, 32'h04);
    op(32'h40400000, 32'h40a00000, 4'h0, 32'h41700000, 4'h0);
    op(32'h3f800001, 32'h3f800001, 4'h0, 32'h3f800002, 4'h1);
    op(32'h7f000000, 32'h7f000000, 4'h0, 32'h7f800000, 4'h5);
    op(32'h00000000, 32'h7f000000, 4'h1, 32'h3f800000, 4'h0);
    op(32'h0d800000, 32'h0d800000, 4'h0, 32'h00000000, 4'h3);
    wb(1, 4'h0, 32'h44);
    op(32'h0d800000, 32'h0d800000, 4'h0, 32'h5b800000, 4'h2);
    wb(1, 4'h0, 32'h04);
    u_fpa_host.run(32'h00400000, 32'h40000000, 4'h0, r, s);
    chk({29'h0, s}, 32'h7);
    wb(1, 4'h0, 32'h0c);
    op(32'h00400000, 32'h40000000, 4'h0, 32'h00000000, 4'h8);
    op(32'h0d800000, 32'h0d800000, 4'h0, 32'h00000000, 4'h8);
    $display("test multiplier done");
    wb(1, 4'h0, 32'h20);
    op(32'h41e80000, 32'h40d00000, 4'h0, 32'h420e0000, 4'h0);
    $display("test flowthrough done");
    results;
  end
endmodule // tb_top
`default_nettype wire
